// ---- inc/nac_regs.vh ----
// Register offsets, field positions, codes and counts of the nonvolatile access controller.
`ifndef NAC_REGS_VH
`define NAC_REGS_VH

// I/O space offsets of the four access registers.
`define NAC_OFF_CTL 6'h1F
`define NAC_OFF_BUF 6'h20
`define NAC_OFF_IDX_LO 6'h21
`define NAC_OFF_IDX_HI 6'h22

// Field positions in the access control register.
`define NAC_CTL_MODE_HI 5
`define NAC_CTL_MODE_LO 4
`define NAC_CTL_RIE 3
`define NAC_CTL_ARM 2
`define NAC_CTL_STRB 1
`define NAC_CTL_RD 0

// Programming action codes.
`define NAC_MODE_ATOMIC 2'h0
`define NAC_MODE_ERASE 2'h1
`define NAC_MODE_PROG 2'h2
`define NAC_MODE_RSVD 2'h3

// Reset values.
`define NAC_RST_MODE 2'h0
`define NAC_RST_BYTE 8'h00
`define NAC_ERASED_BYTE 8'hFF

// Cycle counts on the processor clock.
`define NAC_ARM_CYCLES 3'h4
`define NAC_RD_STALL 3'h4
`define NAC_WR_STALL 3'h2

// Programming intervals in calibrated oscillator cycles.
`define NAC_TICKS_ATOMIC 15'h6700
`define NAC_TICKS_SPLIT 15'h3380
`define NAC_TICK_W 15

`endif

// ---- hdl/nac_array.v ----
// Byte array of the data store with erase, program and atomic write actions.
`timescale 1ns/1ps
`include "nac_regs.vh"

module nac_array #(
    parameter AW = 10,
    parameter DW = 8
) (
    input wire clk_i,
    input wire we_i,
    input wire [1:0] op_i,
    input wire [AW-1:0] waddr_i,
    input wire [DW-1:0] wdata_i,
    input wire [AW-1:0] raddr_i,
    output wire [DW-1:0] rdata_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read is combinational so the controller can fetch a byte in one cycle.
    assign rdata_o = mem[raddr_i];

    // Program only can clear bits, never set them, as in a real cell.
    always @(posedge clk_i) begin
        if (we_i) begin
            case (op_i)
                `NAC_MODE_ATOMIC: begin
                    mem[waddr_i] <= wdata_i;
                end
                `NAC_MODE_ERASE: begin
                    mem[waddr_i] <= {DW{1'b1}};
                end
                `NAC_MODE_PROG: begin
                    mem[waddr_i] <= mem[waddr_i] & wdata_i;
                end
                default: begin
                    mem[waddr_i] <= mem[waddr_i];
                end
            endcase
        end
    end

endmodule

// ---- hdl/nac_ctrl.v ----
// Processor-side access controller for the on-chip nonvolatile byte store.
//
// Overview of operation
// [RQ1] Ten-bit linear byte index, locations 0 to 1023.
// [RQ2] Reserved index and control bits read zero.
// [RQ3] Software loads the index before any access.
// [RQ4] Data register feeds writes, receives read bytes.
// [RQ5] Mode bits select atomic, erase-only or program-only.
// [RQ6] Mode writes ignored while write strobe set.
// [RQ7] Reset clears mode bits unless programming is busy.
// [RQ8] Ready interrupt held while strobe reads zero.
// [RQ9] No ready interrupt during write or self-programming.
// [RQ10] Arm bit self-clears four cycles after setting.
// [RQ11] Strobe starts write only while arm bit set.
// [RQ12] Strobe stays set for interval, hardware clears it.
// [RQ13] Software follows the armed two-step write sequence.
// [RQ14] No array write while flash self-programming runs.
// [RQ15] Read stalls the processor four cycles.
// [RQ16] Write strobe stalls the processor two cycles.
// [RQ17] Write in progress completes across a reset.
// [RQ18] Software masks interrupts during the write sequence; the bench keeps gie set throughout it.
// [RQ19] Read strobe fetches the byte within one access.
// [RQ20] No reads or index changes while writing.
// [RQ21] Interval counted in calibrated oscillator cycles.
// [RQ22] Reserved mode code makes a strobe a no-op.
`timescale 1ns/1ps
`include "nac_regs.vh"

module nac_ctrl #(
    parameter IDX_W = 10,
    parameter [`NAC_TICK_W-1:0] ATOMIC_TICKS = `NAC_TICKS_ATOMIC,
    parameter [`NAC_TICK_W-1:0] SPLIT_TICKS = `NAC_TICKS_SPLIT
) (
    input wire clk_i,
    input wire rst_i,
    input wire por_i,
    input wire [5:0] io_addr_i,
    input wire io_wr_i,
    input wire io_rd_i,
    input wire [7:0] io_wdata_i,
    output reg [7:0] io_rdata_o,
    input wire global_irq_en_i,
    input wire self_prog_active_i,
    input wire rc_clk_i,
    output reg irq_o,
    output reg cpu_stall_o
);

    localparam HI_W = IDX_W - 8;

    function sel;
        input [5:0] addr;
        input [5:0] off;
        begin
            sel = (addr == off);
        end
    endfunction

    // Address decode of the register accesses.
    wire wr_lo = io_wr_i & sel(io_addr_i, `NAC_OFF_IDX_LO);
    wire wr_hi = io_wr_i & sel(io_addr_i, `NAC_OFF_IDX_HI);
    wire wr_buf = io_wr_i & sel(io_addr_i, `NAC_OFF_BUF);
    wire wr_ctl = io_wr_i & sel(io_addr_i, `NAC_OFF_CTL);

    wire [1:0] wr_mode = io_wdata_i[`NAC_CTL_MODE_HI:`NAC_CTL_MODE_LO];

    // Engine state, cleared by power-on (mode also by system reset while idle) so that a write survives reset.
    reg [1:0] mode;
    reg busy;
    reg [`NAC_TICK_W-1:0] tick_cnt;
    reg [IDX_W-1:0] cap_idx;
    reg [7:0] cap_data;
    reg [1:0] cap_mode;
    reg mem_we;
    reg rc_meta;
    reg rc_sync;
    reg rc_last;

    // Processor-side state, cleared by system reset except the index.
    reg rie;
    reg arm;
    reg [2:0] arm_cnt;
    reg [2:0] stall_cnt;
    reg [7:0] buffer;
    reg [IDX_W-1:0] index;

    wire [7:0] mem_rdata;

    // One tick per rising edge of the synchronised oscillator.
    wire rc_tick = rc_sync & ~rc_last;

    // Strobe write accepted only when armed, idle and flash idle.
    wire start_wr = wr_ctl & io_wdata_i[`NAC_CTL_STRB] & arm & ~busy & ~rst_i
                    & ~self_prog_active_i // see [RQ11] see [RQ14]
                    & (wr_mode != `NAC_MODE_RSVD); // see [RQ22]

    // Reads are refused while a write is in progress.
    wire start_rd = wr_ctl & io_wdata_i[`NAC_CTL_RD] & ~busy & ~rst_i; // see [RQ20]

    // Two-stage synchroniser for the calibrated oscillator.
    always @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
            rc_last <= 1'b0;
        end else begin
            rc_meta <= rc_clk_i;
            rc_sync <= rc_meta;
            rc_last <= rc_sync;
        end
    end

    // Self-timed programming engine.
    always @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            busy <= 1'b0;
            tick_cnt <= {`NAC_TICK_W{1'b0}};
            cap_idx <= {IDX_W{1'b0}};
            cap_data <= `NAC_RST_BYTE;
            cap_mode <= `NAC_RST_MODE;
            mem_we <= 1'b0;
        end else begin
            mem_we <= start_wr;
            if (busy) begin
                if (rc_tick) begin
                    // The strobe flag is the busy flag itself. see [RQ12] see [RQ21]
                    if (tick_cnt == {{(`NAC_TICK_W-1){1'b0}}, 1'b1}) begin
                        busy <= 1'b0;
                    end
                    tick_cnt <= tick_cnt - {{(`NAC_TICK_W-1){1'b0}}, 1'b1};
                end
            end else if (start_wr) begin
                busy <= 1'b1;
                // Atomic actions take the full interval, split ones the short one. see [RQ5]
                if (wr_mode == `NAC_MODE_ATOMIC) begin
                    tick_cnt <= ATOMIC_TICKS;
                end else begin
                    tick_cnt <= SPLIT_TICKS;
                end
                cap_idx <= index;
                cap_data <= buffer; // see [RQ4]
                cap_mode <= wr_mode;
            end
        end
    end

    // Mode bits: system reset clears them only while the engine is idle.
    always @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            mode <= `NAC_RST_MODE;
        end else if (!busy) begin
            if (rst_i) begin
                mode <= `NAC_RST_MODE; // see [RQ7] see [RQ17]
            end else if (wr_ctl) begin
                mode <= wr_mode; // see [RQ6]
            end
        end
    end

    // Arm bit with its four-cycle lifetime.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm <= 1'b0;
            arm_cnt <= 3'h0;
        end else if (wr_ctl && io_wdata_i[`NAC_CTL_ARM]) begin
            arm <= 1'b1;
            arm_cnt <= `NAC_ARM_CYCLES;
        end else if (arm_cnt != 3'h0) begin
            // Timing out the arm bit guards against stray strobes. see [RQ10]
            arm_cnt <= arm_cnt - 3'h1;
            arm <= (arm_cnt != 3'h1);
        end else begin
            arm <= 1'b0;
        end
    end

    // Ready-interrupt enable.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rie <= 1'b0;
        end else if (wr_ctl) begin
            rie <= io_wdata_i[`NAC_CTL_RIE];
        end
    end

    // Processor stall after a read or a write strobe.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stall_cnt <= 3'h0;
            cpu_stall_o <= 1'b0;
        end else if (start_rd) begin
            stall_cnt <= `NAC_RD_STALL - 3'h1; // see [RQ15]
            cpu_stall_o <= 1'b1;
        end else if (start_wr) begin
            stall_cnt <= `NAC_WR_STALL - 3'h1; // see [RQ16]
            cpu_stall_o <= 1'b1;
        end else if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
            cpu_stall_o <= 1'b1;
        end else begin
            cpu_stall_o <= 1'b0;
        end
    end

    // Data register: a read fetch takes priority over a software write.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            buffer <= `NAC_RST_BYTE;
        end else if (start_rd) begin
            buffer <= mem_rdata; // see [RQ19] see [RQ4]
        end else if (wr_buf) begin
            buffer <= io_wdata_i;
        end
    end

    // The index has no reset value; software must load it first.
    always @(posedge clk_i) begin
        if (wr_lo && !busy) begin
            index[7:0] <= io_wdata_i; // see [RQ1] see [RQ20]
        end
        if (wr_hi && !busy) begin
            index[IDX_W-1:8] <= io_wdata_i[HI_W-1:0]; // see [RQ1]
        end
    end

    // Level interrupt, held while idle, flash idle and enabled.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= rie & global_irq_en_i & ~busy & ~self_prog_active_i; // see [RQ8] see [RQ9]
        end
    end

    // Read-back; the strobe bits that self-clear show their live state.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
        end else if (!io_rd_i) begin
            io_rdata_o <= 8'h00;
        end else begin
            case (io_addr_i)
                `NAC_OFF_IDX_LO: begin
                    io_rdata_o <= index[7:0];
                end
                `NAC_OFF_IDX_HI: begin
                    io_rdata_o <= {{(16-IDX_W){1'b0}}, index[IDX_W-1:8]}; // see [RQ2]
                end
                `NAC_OFF_BUF: begin
                    io_rdata_o <= buffer;
                end
                `NAC_OFF_CTL: begin
                    io_rdata_o <= {2'h0, mode, rie, arm, busy, 1'b0}; // see [RQ2]
                end
                default: begin
                    io_rdata_o <= 8'h00;
                end
            endcase
        end
    end

    nac_array #(
        .AW(IDX_W),
        .DW(8)
    ) u_array (
        .clk_i(clk_i),
        .we_i(mem_we),
        .op_i(cap_mode),
        .waddr_i(cap_idx),
        .wdata_i(cap_data),
        .raddr_i(index),
        .rdata_o(mem_rdata)
    );

endmodule

// ---- tb/nac_ctrl_assertions.sv ----
// Port-level checker for the access controller.
`timescale 1ns/1ps
`include "nac_regs.vh"
module nac_ctrl_chk (
    input wire clk_i,
    input wire rst_i,
    input wire por_i,
    input wire [5:0] io_addr_i,
    input wire io_wr_i,
    input wire io_rd_i,
    input wire [7:0] io_wdata_i,
    input wire [7:0] io_rdata_o,
    input wire global_irq_en_i,
    input wire self_prog_active_i,
    input wire irq_o,
    input wire cpu_stall_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    logic [2:0] arm_cnt;
    wire ctl_wr = io_wr_i && io_addr_i == `NAC_OFF_CTL;
    wire go = ctl_wr && io_wdata_i[1] && !io_wdata_i[0] && !cpu_stall_o && !self_prog_active_i;
    // Counts the cycles in which a strobe may still find the arm bit set.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_cnt <= 3'h0;
        end else if (ctl_wr && io_wdata_i[2]) begin
            arm_cnt <= 3'h4;
        end else if (arm_cnt != 3'h0) begin
            arm_cnt <= arm_cnt - 3'h1;
        end
    end
    property p_rd_stall;
        ctl_wr && io_wdata_i[0] && !io_wdata_i[1] && irq_o && !cpu_stall_o
            |=> cpu_stall_o [*4] ##1 !cpu_stall_o;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");
    property p_wr_stall;
        go && irq_o && arm_cnt != 3'h0 && io_wdata_i[5:4] != 2'h3
            |=> cpu_stall_o [*2] ##1 !cpu_stall_o;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");
    property p_no_arm;
        go && arm_cnt == 3'h0 && !io_wdata_i[2] |=> !cpu_stall_o;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("unarmed strobe acted");
    property p_rsvd;
        go && arm_cnt != 3'h0 && io_wdata_i[5:4] == 2'h3 |=> !cpu_stall_o;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode strobe acted");
    property p_irq_mask;
        !global_irq_en_i || self_prog_active_i |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("ready irq not masked");
    property p_irq_busy;
        go && irq_o && arm_cnt != 3'h0 && io_wdata_i[5:4] != 2'h3 |-> ##2 !irq_o [*2];
    endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("ready irq during write");
    property p_hi_rsvd;
        io_rd_i && io_addr_i == `NAC_OFF_IDX_HI |=> io_rdata_o[7:2] == 6'h00;
    endproperty
    a_hi_rsvd: assert property (p_hi_rsvd) else $error("index high reserved bits set");
    property p_ctl_rd;
        io_rd_i && io_addr_i == `NAC_OFF_CTL && !io_wr_i |=> io_rdata_o[7:6] == 2'h0
            && !io_rdata_o[0] && io_rdata_o[2] == ($past(arm_cnt) != 3'h0);
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
endmodule
bind nac_ctrl nac_ctrl_chk i_chk (.clk_i, .rst_i, .por_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_wdata_i, .io_rdata_o, .global_irq_en_i, .self_prog_active_i, .irq_o, .cpu_stall_o);

// ---- tb/nac_cpu_model.sv ----
// Processor core model issuing I/O accesses and honouring stalls.
`timescale 1ns/1ps
module nac_cpu_model (
    input wire clk_i,
    input wire stall_i,
    input wire [7:0] rdata_i,
    output logic [5:0] addr_o = 6'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [7:0] wdata_o = 8'h00
);
    // A bounded wait, so a stuck stall cannot hang the core.
    task automatic hold_off();
        int n;
        n = 0;
        #1;
        while (stall_i === 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        hold_off();
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the access controller.
`timescale 1ns/1ps
`include "nac_regs.vh"
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_i = 1'b1;
    logic gie = 1'b0;
    logic spm = 1'b0;
    logic rc_clk = 1'b0;
    logic [5:0] addr;
    logic wr, rd, stall, irq;
    logic [7:0] wdata, rdata, v;
    logic [7:0] dat [4] = '{8'hA5, 8'h00, 8'h3C, 8'h00};
    logic [7:0] exp [4] = '{8'hA5, 8'hFF, 8'h3C, 8'h3C};
    int err_total = 0;
    int total_checks = 0;
    initial forever #10 clk_i = ~clk_i;
    initial forever #151 rc_clk = ~rc_clk;
    nac_ctrl #(.ATOMIC_TICKS(15'h0008), .SPLIT_TICKS(15'h0004)) i_dut (.clk_i(clk_i),
        .rst_i(rst_i), .por_i(por_i), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
        .io_wdata_i(wdata), .io_rdata_o(rdata), .global_irq_en_i(gie),
        .self_prog_active_i(spm), .rc_clk_i(rc_clk), .irq_o(irq), .cpu_stall_o(stall));
    nac_cpu_model i_cpu (.clk_i(clk_i), .stall_i(stall), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic set_idx(input logic [9:0] x);
        i_cpu.wr(`NAC_OFF_IDX_HI, {6'h00, x[9:8]});
        i_cpu.wr(`NAC_OFF_IDX_LO, x[7:0]);
    endtask
    task automatic start_wr(input logic [9:0] x, input logic [7:0] d, input logic [1:0] m,
                            input int gap);
        set_idx(x);
        i_cpu.wr(`NAC_OFF_BUF, d);
        i_cpu.wr(`NAC_OFF_CTL, 8'h0C);
        repeat (gap) @(posedge clk_i);
        i_cpu.wr(`NAC_OFF_CTL, {2'h0, m, 4'hA});
    endtask
    task automatic fetch(input logic [9:0] x, output logic [7:0] d);
        set_idx(x);
        i_cpu.wr(`NAC_OFF_CTL, 8'h09);
        i_cpu.rd(`NAC_OFF_BUF, d);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        v = 8'h02;
        while (v[1] === 1'b1 && n < 200) begin
            i_cpu.rd(`NAC_OFF_CTL, v);
            n++;
        end
        check8("strobe", 8'h00, {7'h0, v[1]});
    endtask
    task automatic pulse_rst();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        gie <= 1'b1;
        // Each mode except the reserved one, whose strobe is a no-op, acts on the byte that the previous pass left at the top index.
        for (int i = 0; i < 4; i++) begin
            start_wr(10'h3FF, dat[i], i[1:0], 0);
            wait_idle();
            fetch(10'h3FF, v);
            check8("byte", exp[i], v);
        end
        start_wr(10'h3FF, 8'h11, 2'h0, 4);
        fetch(10'h3FF, v);
        check8("late strobe", 8'h3C, v);
        check8("irq idle", 8'h01, {7'h0, irq});
        start_wr(10'h005, 8'h5A, 2'h1, 0);
        check8("irq busy", 8'h00, {7'h0, irq});
        set_idx(10'h001);
        i_cpu.wr(`NAC_OFF_CTL, 8'h09);
        i_cpu.rd(`NAC_OFF_CTL, v);
        check8("ctl busy", 8'h1A, v);
        i_cpu.rd(`NAC_OFF_BUF, v);
        check8("buf busy", 8'h5A, v);
        pulse_rst();
        i_cpu.rd(`NAC_OFF_CTL, v);
        check8("ctl rst busy", 8'h12, v);
        wait_idle();
        i_cpu.rd(`NAC_OFF_IDX_LO, v);
        check8("index", 8'h05, v);
        fetch(10'h005, v);
        check8("erased", 8'hFF, v);
        pulse_rst();
        i_cpu.rd(`NAC_OFF_CTL, v);
        check8("ctl rst", 8'h00, v);
        @(posedge clk_i);
        spm <= 1'b1;
        start_wr(10'h3FF, 8'h00, 2'h0, 0);
        check8("irq spm", 8'h00, {7'h0, irq});
        @(posedge clk_i);
        spm <= 1'b0;
        fetch(10'h3FF, v);
        check8("spm write", 8'h3C, v);
        i_cpu.wr(`NAC_OFF_IDX_HI, 8'hFF);
        i_cpu.rd(`NAC_OFF_IDX_HI, v);
        check8("index high", 8'h03, v);
        i_cpu.rd(6'h3E, v);
        check8("unmapped", 8'h00, v);
        complete_run();
    end
endmodule
